// ==== core/dpcfq_pkg.sv ====
// Shared constants and types for the drive program command and fault queue block
package dpcfq_pkg;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register word offsets
  localparam logic [7:0] OFS_PROG_STATE  = 8'h00;
  localparam logic [7:0] OFS_SCAN_TIME   = 8'h01;
  localparam logic [7:0] OFS_CMD_WORD    = 8'h02;
  localparam logic [7:0] OFS_SPEED_REF   = 8'h03;
  localparam logic [7:0] OFS_FAULT_SLOT0 = 8'h04;
  localparam logic [7:0] OFS_SRC_CFG     = 8'h09;
  localparam logic [7:0] OFS_MAX_SPEED   = 8'h0A;
  localparam logic [7:0] OFS_DRIVE_STAT  = 8'h0B;
  localparam logic [7:0] OFS_FAULT_RESET = 8'h0C;
  localparam logic [7:0] OFS_HIST_CODE0  = 8'h20;
  localparam logic [7:0] OFS_HIST_HI0    = 8'h30;
  localparam logic [7:0] OFS_HIST_LO0    = 8'h40;

  // Program state codes
  localparam logic [15:0] PST_NONE    = 16'h0000;
  localparam logic [15:0] PST_SAVING  = 16'h0001;
  localparam logic [15:0] PST_INVALID = 16'h0002;
  localparam logic [15:0] PST_STOPPED = 16'h0003;
  localparam logic [15:0] PST_RUNNING = 16'h0004;

  // Command word bit positions
  localparam int CMD_RAMP_EN   = 0;
  localparam int CMD_GEN_EN    = 1;
  localparam int CMD_REVERSE   = 2;
  localparam int CMD_JOG       = 3;
  localparam int CMD_REMOTE2   = 4;
  localparam int CMD_RAMP2     = 5;
  localparam int CMD_NO_QSTOP  = 6;
  localparam int CMD_FLT_RESET = 7;

  // Source configuration bits
  localparam int CFG_CMD_PLC = 0;
  localparam int CFG_REF_PLC = 1;

  // Speed reference scale, hundredths of a percent, and scan time ceiling
  localparam logic signed [15:0] REF_LIMIT      = 16'h4E20;
  localparam logic [31:0]        REF_FULL_SCALE = 32'h0000_2710;
  localparam logic [15:0]        SCAN_MAX       = 16'hFFFF;

  // Scan timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // Fault queue geometry
  localparam int SLOTS      = 5;
  localparam int HIST_DEPTH = 10;
  localparam int CODE_W     = 12;
  localparam int STAMP_W    = 32;
  localparam logic [11:0] CODE_NONE = 12'h000;

  // Reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_CMD   = 8'h00;
  localparam logic [1:0]  RST_CFG   = 2'h0;
  localparam logic [15:0] RST_MAXSP = 16'h0708;

  typedef logic [CODE_W-1:0]  dpcfq_code_t;
  typedef logic [STAMP_W-1:0] dpcfq_stamp_t;
endpackage

// ==== core/dpcfq_fault_if.sv ====
// Interface between the register bank and the fault queue
`timescale 1ns/1ps
interface dpcfq_fault_if;
  logic                  new_valid;
  dpcfq_pkg::dpcfq_code_t  new_code;
  dpcfq_pkg::dpcfq_stamp_t new_stamp;
  logic                  clear_first;
  dpcfq_pkg::dpcfq_code_t  slot_code [dpcfq_pkg::SLOTS];
  dpcfq_pkg::dpcfq_code_t  hist_code [dpcfq_pkg::HIST_DEPTH];
  dpcfq_pkg::dpcfq_stamp_t hist_stamp [dpcfq_pkg::HIST_DEPTH];
  logic                  any_active;

  modport queue (input new_valid, new_code, new_stamp, clear_first,
                 output slot_code, hist_code, hist_stamp, any_active);
  modport user  (output new_valid, new_code, new_stamp, clear_first,
                 input slot_code, hist_code, hist_stamp, any_active);
endinterface

// ==== core/dpcfq_fault_queue.sv ====
// Five-slot active fault queue with ten-deep fault history
`timescale 1ns/1ps
module dpcfq_fault_queue (
  input  wire logic  sys_clk,
  input  wire logic  reset,
  dpcfq_fault_if.queue fq
);
  localparam int N = dpcfq_pkg::SLOTS;
  localparam int H = dpcfq_pkg::HIST_DEPTH;

  dpcfq_pkg::dpcfq_code_t  slot_q [N];
  dpcfq_pkg::dpcfq_code_t  hcode_q [H];
  dpcfq_pkg::dpcfq_stamp_t hstamp_q [H];
  logic [N-1:0]            empty;
  logic [N-1:0]            pick;
  logic                    take;

  // Slot 0 counts as free when it is being cleared, so a fault in the same cycle is kept
  always_comb begin
    for (int i = 0; i < N; i++) begin
      empty[i] = (slot_q[i] == dpcfq_pkg::CODE_NONE);
    end
    if (fq.clear_first) begin
      empty[0] = 1'b1;
    end
  end

  always_comb begin
    pick = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (empty[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end

  // full queue drops fault; code zero is not a fault
  assign take = fq.new_valid && (fq.new_code != dpcfq_pkg::CODE_NONE) && (|empty);

  generate
    for (genvar g = 0; g < N; g++) begin : g_slot
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          slot_q[g] <= dpcfq_pkg::CODE_NONE;
        end else if (take && pick[g]) begin
          slot_q[g] <= fq.new_code;
        end else if (fq.clear_first && g == 0) begin
          slot_q[g] <= dpcfq_pkg::CODE_NONE;
        end
      end
      assign fq.slot_code[g] = slot_q[g];
    end
    // history shifts, newest at entry 0
    for (genvar h = 0; h < H; h++) begin : g_hist
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          hcode_q[h]  <= dpcfq_pkg::CODE_NONE;
          hstamp_q[h] <= '0;
        end else if (fq.new_valid && fq.new_code != dpcfq_pkg::CODE_NONE) begin
          hcode_q[h]  <= (h == 0) ? fq.new_code : hcode_q[(h == 0) ? 0 : h - 1];
          hstamp_q[h] <= (h == 0) ? fq.new_stamp : hstamp_q[(h == 0) ? 0 : h - 1];
        end
      end
      assign fq.hist_code[h]  = hcode_q[h];
      assign fq.hist_stamp[h] = hstamp_q[h];
    end
  endgenerate

  // Any occupied slot means a fault is active
  always_comb begin
    fq.any_active = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (slot_q[i] != dpcfq_pkg::CODE_NONE) begin
        fq.any_active = 1'b1;
      end
    end
  end
endmodule

// ==== core/dpcfq_top.sv ====
// Program command word, speed reference, status and fault register bank
//
// Contract
// - Program state reported as code 0 to 4
// - No program hides user parameters
// - Stored program, firmware mismatch, reports invalid
// - Scan time in ms, 0 to 65535
// - Only the program writes command and reference
// - Commands act only with program command source
// - Bit 0 ramps up, else ramp stop
// - Bit 1 low disables drive, cuts power
// - Bit 2 high reverses reference direction
// - Bit 3 enables jog
// - Bit 4 selects remote mode two
// - Bit 5 selects second ramp set
// - Bit 6 low enables quick stop
// - Bit 7 rising edge resets active fault
// - Reference in hundredths percent of maximum speed
// - Reference used only with program reference source
// - Direction from reference sign and direction bit
// - Fault slot holds 0 to 4095, 0 empty
// - Active fault disables motor until reset
// - Five faults, lowest empty slot first
// - Reset command clears only first slot
// - Ten most recent faults kept with stamps
`timescale 1ns/1ps
module dpcfq_top #(
  parameter int MS_CYCLES = dpcfq_pkg::MS_CYCLES
) (
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  // Software register port
  input  wire logic [dpcfq_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [dpcfq_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [dpcfq_pkg::DATA_W-1:0]     reg_rdata,
  // Embedded program side
  input  wire logic                             prog_stored,
  input  wire logic                             prog_saving,
  input  wire logic                             prog_fw_match,
  input  wire logic                             prog_running,
  input  wire logic                             prog_scan_start,
  input  wire logic                             prog_cmd_wr,
  input  wire logic                             prog_ref_wr,
  input  wire logic [dpcfq_pkg::DATA_W-1:0]     prog_wdata,
  // Alternate command source
  input  wire logic [7:0]                       alt_cmd_word,
  input  wire logic [dpcfq_pkg::DATA_W-1:0]     alt_speed_ref,
  // Fault reporting
  input  wire logic                             fault_valid,
  input  wire logic [dpcfq_pkg::CODE_W-1:0]     fault_code,
  input  wire logic [dpcfq_pkg::STAMP_W-1:0]    fault_stamp,
  // Drive controls
  output logic                                  ramp_enable,
  output logic                                  general_enable,
  output logic                                  run_reverse,
  output logic                                  jog_enable,
  output logic                                  remote_mode_two,
  output logic                                  second_ramp,
  output logic                                  quick_stop,
  output logic                                  motor_forward,
  output logic [16:0]                           speed_ref_rpm,
  output logic                                  hide_user_params,
  output logic                                  fault_active
);
  dpcfq_fault_if fq ();

  logic [15:0] state_d;
  logic [15:0] state_q;
  logic [15:0] scan_time_q;
  logic [15:0] ms_count_q;
  logic [31:0] tick_q;
  logic [7:0]  cmd_word_q;
  logic [15:0] speed_ref_q;
  logic [1:0]  src_cfg_q;
  logic [15:0] max_speed_q;
  logic        reset_bit_q;
  logic        sw_reset_q;
  logic [7:0]  eff_cmd;
  logic [15:0] eff_ref;
  logic        ref_neg;
  logic [15:0] ref_mag;
  logic [31:0] product;
  logic [31:0] rpm_full;
  logic        cmd_plc;
  logic        plc_reset_edge;
  logic        wr_hit;
  logic [15:0] rdata_d;
  logic [15:0] drive_stat;
  logic [7:0]  rel;

  dpcfq_fault_queue u_queue (
    .sys_clk (sys_clk),
    .reset   (reset),
    .fq      (fq.queue)
  );

  always_comb begin
    if (!prog_stored) begin
      state_d = dpcfq_pkg::PST_NONE;
    end else if (prog_saving) begin
      state_d = dpcfq_pkg::PST_SAVING;
    end else if (!prog_fw_match) begin
      state_d = dpcfq_pkg::PST_INVALID;
    end else if (prog_running) begin
      state_d = dpcfq_pkg::PST_RUNNING;
    end else begin
      state_d = dpcfq_pkg::PST_STOPPED;
    end
  end

  // Saving takes priority over a stored flag left from an older program
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= dpcfq_pkg::PST_NONE;
    end else begin
      state_q <= (prog_saving) ? dpcfq_pkg::PST_SAVING : state_d;
    end
  end

  // hide user parameters without a program
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hide_user_params <= 1'b1;
    end else begin
      hide_user_params <= (state_d == dpcfq_pkg::PST_NONE) && !prog_saving;
    end
  end

  // Millisecond tick divider
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_q <= '0;
    end else if (prog_scan_start || tick_q == 32'(MS_CYCLES - 1)) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ms_count_q  <= dpcfq_pkg::RST_WORD;
      scan_time_q <= dpcfq_pkg::RST_WORD;
    end else if (prog_scan_start) begin
      scan_time_q <= ms_count_q;
      ms_count_q  <= dpcfq_pkg::RST_WORD;
    end else if (tick_q == 32'(MS_CYCLES - 1) && ms_count_q != dpcfq_pkg::SCAN_MAX) begin
      ms_count_q <= ms_count_q + 16'h0001;
    end
  end

  // only program writes change command word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd_word_q <= dpcfq_pkg::RST_CMD;
    end else if (prog_cmd_wr) begin
      cmd_word_q <= prog_wdata[7:0];
    end
  end

  // reference clamped to plus or minus 200.00 percent
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      speed_ref_q <= dpcfq_pkg::RST_WORD;
    end else if (prog_ref_wr) begin
      if ($signed(prog_wdata) > dpcfq_pkg::REF_LIMIT) begin
        speed_ref_q <= dpcfq_pkg::REF_LIMIT;
      end else if ($signed(prog_wdata) < -dpcfq_pkg::REF_LIMIT) begin
        speed_ref_q <= -dpcfq_pkg::REF_LIMIT;
      end else begin
        speed_ref_q <= prog_wdata;
      end
    end
  end

  // Software write decode; command and reference offsets are read only here
  assign wr_hit = reg_wr && !reg_rd;

  // Source selection and maximum speed setting
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      src_cfg_q   <= dpcfq_pkg::RST_CFG;
      max_speed_q <= dpcfq_pkg::RST_MAXSP;
    end else if (wr_hit && reg_addr == dpcfq_pkg::OFS_SRC_CFG) begin
      src_cfg_q <= reg_wdata[1:0];
    end else if (wr_hit && reg_addr == dpcfq_pkg::OFS_MAX_SPEED) begin
      max_speed_q <= reg_wdata;
    end
  end

  // Software fault reset is a one-cycle pulse
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= wr_hit && reg_addr == dpcfq_pkg::OFS_FAULT_RESET && reg_wdata[0];
    end
  end

  // program commands act only when selected
  assign cmd_plc = src_cfg_q[dpcfq_pkg::CFG_CMD_PLC];
  assign eff_cmd = cmd_plc ? cmd_word_q : alt_cmd_word;
  assign eff_ref = src_cfg_q[dpcfq_pkg::CFG_REF_PLC] ? speed_ref_q : alt_speed_ref;

  // Edge memory for the fault reset bit; follows the effective word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reset_bit_q <= 1'b0;
    end else begin
      reset_bit_q <= eff_cmd[dpcfq_pkg::CMD_FLT_RESET];
    end
  end

  // rising edge only resets a fault
  assign plc_reset_edge = eff_cmd[dpcfq_pkg::CMD_FLT_RESET] && !reset_bit_q;

  // Fault queue requests
  always_comb begin
    fq.new_valid   = fault_valid;
    fq.new_code    = fault_code;
    fq.new_stamp   = fault_stamp;
    fq.clear_first = (plc_reset_edge || sw_reset_q) && fq.any_active;
  end

  // Decoded drive commands
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ramp_enable     <= 1'b0;
      general_enable  <= 1'b0;
      run_reverse     <= 1'b0;
      jog_enable      <= 1'b0;
      remote_mode_two <= 1'b0;
      second_ramp     <= 1'b0;
      quick_stop      <= 1'b0;
      fault_active    <= 1'b0;
    end else begin
      ramp_enable     <= eff_cmd[dpcfq_pkg::CMD_RAMP_EN] && !fq.any_active;
      general_enable  <= eff_cmd[dpcfq_pkg::CMD_GEN_EN] && !fq.any_active;
      run_reverse     <= eff_cmd[dpcfq_pkg::CMD_REVERSE];
      jog_enable      <= eff_cmd[dpcfq_pkg::CMD_JOG];
      remote_mode_two <= eff_cmd[dpcfq_pkg::CMD_REMOTE2];
      second_ramp     <= eff_cmd[dpcfq_pkg::CMD_RAMP2];
      quick_stop      <= !eff_cmd[dpcfq_pkg::CMD_NO_QSTOP];
      fault_active    <= fq.any_active;
    end
  end

  // Magnitude of the signed reference
  assign ref_neg  = eff_ref[15];
  assign ref_mag  = ref_neg ? 16'(-eff_ref) : eff_ref;
  // scale against maximum speed; 200 percent of 65535 fits 17 bits
  assign product  = 32'(ref_mag) * 32'(max_speed_q);
  assign rpm_full = product / dpcfq_pkg::REF_FULL_SCALE;

  // Speed and direction outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      speed_ref_rpm <= '0;
      motor_forward <= 1'b1;
    end else begin
      speed_ref_rpm <= rpm_full[16:0];
      // forward when direction bit matches positive sign
      motor_forward <= (!eff_cmd[dpcfq_pkg::CMD_REVERSE]) ^ ref_neg;
    end
  end

  // Live drive status bits for software
  assign drive_stat = {7'h00, fault_active, quick_stop, second_ramp, remote_mode_two,
                       jog_enable, run_reverse, general_enable, ramp_enable, motor_forward};

  assign rel = reg_addr;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = dpcfq_pkg::RST_WORD;
    if (rel == dpcfq_pkg::OFS_PROG_STATE) begin
      rdata_d = state_q;
    end else if (rel == dpcfq_pkg::OFS_SCAN_TIME) begin
      rdata_d = scan_time_q;
    end else if (rel == dpcfq_pkg::OFS_CMD_WORD) begin
      rdata_d = {8'h00, cmd_word_q};
    end else if (rel == dpcfq_pkg::OFS_SPEED_REF) begin
      rdata_d = speed_ref_q;
    end else if (rel == dpcfq_pkg::OFS_SRC_CFG) begin
      rdata_d = {14'h0000, src_cfg_q};
    end else if (rel == dpcfq_pkg::OFS_MAX_SPEED) begin
      rdata_d = max_speed_q;
    end else if (rel == dpcfq_pkg::OFS_DRIVE_STAT) begin
      rdata_d = drive_stat;
    end
    // slot codes zero-extended, zero when empty
    for (int i = 0; i < dpcfq_pkg::SLOTS; i++) begin
      if (rel == dpcfq_pkg::OFS_FAULT_SLOT0 + 8'(i)) begin
        rdata_d = 16'(fq.slot_code[i]);
      end
    end
    for (int h = 0; h < dpcfq_pkg::HIST_DEPTH; h++) begin
      if (rel == dpcfq_pkg::OFS_HIST_CODE0 + 8'(h)) begin
        rdata_d = 16'(fq.hist_code[h]);
      end else if (rel == dpcfq_pkg::OFS_HIST_HI0 + 8'(h)) begin
        rdata_d = fq.hist_stamp[h][31:16];
      end else if (rel == dpcfq_pkg::OFS_HIST_LO0 + 8'(h)) begin
        rdata_d = fq.hist_stamp[h][15:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= dpcfq_pkg::RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= dpcfq_pkg::RST_WORD;
    end
  end
endmodule

// ==== testbench/dpcfq_top_properties.sv ====
// Port checker for the program command and fault queue block
`timescale 1ns/1ps
module dpcfq_checker #(
  parameter int MS_CYCLES = 25
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        prog_stored,
  input wire logic        prog_saving,
  input wire logic        fault_valid,
  input wire logic [11:0] fault_code,
  input wire logic        ramp_enable,
  input wire logic        general_enable,
  input wire logic        run_reverse,
  input wire logic        jog_enable,
  input wire logic        remote_mode_two,
  input wire logic        second_ramp,
  input wire logic        quick_stop,
  input wire logic        motor_forward,
  input wire logic        hide_user_params,
  input wire logic        fault_active
);
  // Status word as the register port should echo it
  wire [8:0] stat = {fault_active, quick_stop, second_ramp, remote_mode_two, jog_enable,
                     run_reverse, general_enable, ramp_enable, motor_forward};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  state_range_a: assert property ($past(reg_rd)
    && $past(reg_addr) == dpcfq_pkg::OFS_PROG_STATE |-> reg_rdata <= dpcfq_pkg::PST_RUNNING)
    else $error("program state code out of range");
  status_echo_a: assert property ($past(reg_rd)
    && $past(reg_addr) == dpcfq_pkg::OFS_DRIVE_STAT |-> reg_rdata == {7'h00, $past(stat)})
    else $error("status read differs from outputs");
  save_shown_a: assert property (prog_saving [*3] |=> !hide_user_params)
    else $error("parameters hidden while saving");
  no_prog_hide_a: assert property ((!prog_stored && !prog_saving) [*3] |=> hide_user_params)
    else $error("parameters shown with no program");
  slot_range_a: assert property ($past(reg_rd)
    && $past(reg_addr) inside {[8'h04:8'h08]} |-> reg_rdata[15:12] == 4'h0)
    else $error("fault slot above 4095");
  fault_sets_a: assert property (fault_valid && fault_code != 12'h000 |-> ##2 fault_active)
    else $error("fault not active two cycles after report");
  fault_blocks_a: assert property (fault_active |-> !ramp_enable && !general_enable)
    else $error("motor enabled during active fault");
  fault_cause_a: assert property ($rose(fault_active) |-> $past(fault_valid, 2))
    else $error("fault active without a report");
endmodule

bind dpcfq_top dpcfq_checker #(.MS_CYCLES(MS_CYCLES)) chk (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .prog_stored(prog_stored), .prog_saving(prog_saving),
  .fault_valid(fault_valid), .fault_code(fault_code), .ramp_enable(ramp_enable),
  .general_enable(general_enable), .run_reverse(run_reverse), .jog_enable(jog_enable),
  .remote_mode_two(remote_mode_two), .second_ramp(second_ramp), .quick_stop(quick_stop),
  .motor_forward(motor_forward), .hide_user_params(hide_user_params),
  .fault_active(fault_active));

// ==== testbench/dpcfq_prog_model.sv ====
// Behavioural model of the user program running inside the drive
`timescale 1ns/1ps
module dpcfq_prog_model (
  input  wire logic        sys_clk,
  output logic             prog_stored,
  output logic             prog_saving,
  output logic             prog_fw_match,
  output logic             prog_running,
  output logic             prog_scan_start,
  output logic             prog_cmd_wr,
  output logic             prog_ref_wr,
  output logic [15:0]      prog_wdata
);
  // Nothing stored and no traffic at time zero
  initial begin
    {prog_stored, prog_saving, prog_fw_match, prog_running} = 4'h0;
    {prog_scan_start, prog_cmd_wr, prog_ref_wr} = 3'h0;
    prog_wdata = 16'h0000;
  end

  // Program memory condition as {stored, saving, match, running}
  task set_state(input logic [3:0] s);
    @(posedge sys_clk);
    {prog_stored, prog_saving, prog_fw_match, prog_running} <= s;
  endtask

  task write(input logic to_ref, input logic [15:0] d);
    @(posedge sys_clk);
    prog_wdata  <= d;
    prog_cmd_wr <= !to_ref;
    prog_ref_wr <= to_ref;
    @(posedge sys_clk);
    prog_cmd_wr <= 1'b0;
    prog_ref_wr <= 1'b0;
    prog_wdata  <= ~d; // Released data never shows the stale value
  endtask

  task scan_mark();
    @(posedge sys_clk);
    prog_scan_start <= 1'b1;
    @(posedge sys_clk);
    prog_scan_start <= 1'b0;
  endtask
endmodule

// ==== testbench/dpcfq_tb_top.sv ====
// Self-checking bench for the program command and fault queue block
`timescale 1ns/1ps
module dpcfq_tb_top;
  localparam int MS = 25;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        prog_stored, prog_saving, prog_fw_match, prog_running;
  logic        prog_scan_start, prog_cmd_wr, prog_ref_wr;
  logic [15:0] prog_wdata;
  logic [7:0]  alt_cmd_word = 8'h00;
  logic [15:0] alt_speed_ref = 16'h0000;
  logic        fault_valid = 1'b0;
  logic [11:0] fault_code = 12'h000;
  logic [31:0] fault_stamp = 32'h0000_0000;
  logic        ramp_enable, general_enable, run_reverse, jog_enable, remote_mode_two;
  logic        second_ramp, quick_stop, motor_forward, hide_user_params, fault_active;
  logic [16:0] speed_ref_rpm;
  int          mismatches = 0;
  int          checks = 0;

  // Short ms divider keeps scan runs cheap
  dpcfq_top #(.MS_CYCLES(MS)) uut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_stored(prog_stored),
    .prog_saving(prog_saving), .prog_fw_match(prog_fw_match), .prog_running(prog_running),
    .prog_scan_start(prog_scan_start), .prog_cmd_wr(prog_cmd_wr), .prog_ref_wr(prog_ref_wr),
    .prog_wdata(prog_wdata), .alt_cmd_word(alt_cmd_word), .alt_speed_ref(alt_speed_ref),
    .fault_valid(fault_valid), .fault_code(fault_code), .fault_stamp(fault_stamp),
    .ramp_enable(ramp_enable), .general_enable(general_enable), .run_reverse(run_reverse),
    .jog_enable(jog_enable), .remote_mode_two(remote_mode_two), .second_ramp(second_ramp),
    .quick_stop(quick_stop), .motor_forward(motor_forward), .speed_ref_rpm(speed_ref_rpm),
    .hide_user_params(hide_user_params), .fault_active(fault_active));

  // User program on the far side
  dpcfq_prog_model pm (
    .sys_clk(sys_clk), .prog_stored(prog_stored), .prog_saving(prog_saving),
    .prog_fw_match(prog_fw_match), .prog_running(prog_running),
    .prog_scan_start(prog_scan_start), .prog_cmd_wr(prog_cmd_wr),
    .prog_ref_wr(prog_ref_wr), .prog_wdata(prog_wdata));

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  task chk(input string n, input logic [16:0] s, input logic [16:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask

  // Outputs follow two edges after a write
  task settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task fault(input logic [11:0] c);
    @(posedge sys_clk);
    fault_valid <= 1'b1;
    fault_code  <= c;
    fault_stamp <= {4'h0, c, 4'h5, c};
    @(posedge sys_clk);
    fault_valid <= 1'b0;
    fault_code  <= ~c;
  endtask
  task t_reset();
    rdchk("cfg", dpcfq_pkg::OFS_SRC_CFG, 16'h0000);
    rdchk("maxsp", dpcfq_pkg::OFS_MAX_SPEED, 16'h0708);
    rdchk("cmd", dpcfq_pkg::OFS_CMD_WORD, 16'h0000);
    rdchk("stat", dpcfq_pkg::OFS_DRIVE_STAT, 16'h0081);
    rdchk("unmapped", 8'hFF, 16'h0000);
    chk("hide", hide_user_params, 1'b1);
  endtask

  // Memory conditions map to codes 0 to 4
  task t_state();
    logic [3:0] st [5];
    st = '{4'h0, 4'h4, 4'h8, 4'hA, 4'hB};
    for (int i = 0; i < 5; i++) begin
      pm.set_state(st[i]);
      settle();
      rdchk("state", dpcfq_pkg::OFS_PROG_STATE, 16'(i));
      chk("hide", hide_user_params, i == 0);
    end
  endtask

  task t_cmd();
    logic [7:0] c;
    wr(dpcfq_pkg::OFS_SRC_CFG, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      c = 8'h01 << i;
      pm.write(1'b0, {8'h00, c});
      settle();
      chk("ctl", {quick_stop, second_ramp, remote_mode_two, jog_enable, run_reverse,
                  general_enable, ramp_enable, motor_forward}, {~c[6], c[5:0], ~c[2]});
    end
    wr(dpcfq_pkg::OFS_CMD_WORD, 16'h00FF);
    rdchk("cmd", dpcfq_pkg::OFS_CMD_WORD, 16'h0040);
    wr(dpcfq_pkg::OFS_SRC_CFG, 16'h0000);
    settle();
    chk("qstop", quick_stop, 1'b1);
  endtask

  // Plus and minus half speed, with and without the reverse bit
  task t_ref();
    logic [15:0] cm [4];
    logic [15:0] rf [4];
    cm = '{16'h0042, 16'h0042, 16'h0046, 16'h0046};
    rf = '{16'h1388, 16'hEC78, 16'h1388, 16'hEC78};
    wr(dpcfq_pkg::OFS_SRC_CFG, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      pm.write(1'b0, cm[i]);
      pm.write(1'b1, rf[i]);
      settle();
      chk("rpm", speed_ref_rpm, 16'h0384);
      chk("fwd", motor_forward, rf[i][15] == cm[i][2]);
    end
    pm.write(1'b1, 16'h61A8);
    alt_speed_ref <= 16'h2710;
    settle();
    chk("clamp", speed_ref_rpm, 16'h0E10);
    rdchk("ref", dpcfq_pkg::OFS_SPEED_REF, 16'h4E20);
    wr(dpcfq_pkg::OFS_SRC_CFG, 16'h0001);
    wr(dpcfq_pkg::OFS_MAX_SPEED, 16'h0E10);
    settle();
    chk("altref", speed_ref_rpm, 16'h0E10);
  endtask

  task t_scan();
    pm.scan_mark();
    repeat (3 * MS + 5) @(posedge sys_clk);
    pm.scan_mark();
    settle();
    rdchk("scan", dpcfq_pkg::OFS_SCAN_TIME, 16'h0003);
  endtask

  task t_fault();
    wr(dpcfq_pkg::OFS_SRC_CFG, 16'h0000);
    alt_cmd_word <= 8'h02;
    fault(12'h000);
    settle();
    chk("nofault", fault_active, 1'b0);
    for (int i = 1; i <= 5; i++) fault(12'h100 + 12'(i));
    fault(12'hFFF);
    settle();
    for (int i = 0; i < 5; i++)
      rdchk("slot", 8'h04 + 8'(i), 16'h0101 + 16'(i));
    chk("gen", general_enable, 1'b0);
    rdchk("hist", dpcfq_pkg::OFS_HIST_CODE0, 16'h0FFF);
    rdchk("stamp_hi", dpcfq_pkg::OFS_HIST_HI0, 16'h0FFF);
    rdchk("stamp_lo", dpcfq_pkg::OFS_HIST_LO0, 16'h5FFF);
    wr(dpcfq_pkg::OFS_FAULT_RESET, 16'h0001);
    settle();
    rdchk("slot1", 8'h04, 16'h0000);
    rdchk("slot2", 8'h05, 16'h0102);
    fault(12'h0AB);
    settle();
    rdchk("slot1", 8'h04, 16'h00AB);
    @(posedge sys_clk) alt_cmd_word <= 8'h82;
    settle();
    rdchk("slot1", 8'h04, 16'h0000);
    chk("active", fault_active, 1'b1);
  endtask

  task report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_state();
    t_cmd();
    t_ref();
    t_scan();
    t_fault();
    report_and_stop();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end
endmodule
